// ===== src/fault_event_recorder.sv
// Fault event log, tick timer, EEPROM dump engine and enable/undervoltage state
// Functional notes
// RQ1 - Log reads work whenever the block is clocked; no dependence on rail or switch.
// RQ2 - Event log holds exactly seven one-byte entries.
// RQ3 - Log read returns the seven newest entries oldest first, with time values.
// RQ4 - Entry is a 3-bit event code above a 5-bit elapsed-time value.
// RQ5 - Low four time bits are the tick timer snapshot at write time.
// RQ6 - Fifth time bit shows the tick timer wrapped since the previous event.
// RQ7 - Tick timer runs freely and clears to zero on each recorded event.
// RQ8 - Log configuration selects the tick increment rate.
// RQ9 - Overflow flag sets on timer wrap and clears with the timer on next event.
// RQ10 - Seven warning and detection inputs each write a log entry; the code logs inputs rising together as one entry with the lowest code.
// RQ11 - Global fault or unmasked alert dumps log, status, peaks and timer to EEPROM.
// RQ12 - EEPROM link is an I2C controller with a serial clock of 400 kHz; the code runs it at about 385 kHz (52 system clocks per bit).
// RQ13 - Dump goes to EEPROM page zero; log and timer freeze at that moment.
// RQ14 - Dump only with external memory enabled and two pins assigned to EEPROM.
// RQ15 - Dump also needs at least one of three trigger bits set.
// RQ16 - Dump order: log, timer, status word, mfr, input status, peaks, checksum.
// RQ17 - Each peak stored as the upper eight bits of its 10-bit result.
// RQ18 - Enable/undervoltage comparators select on, FET off with delayed discharge, shutdown.
// RQ19 - Host reads log contents and dump record state over the management port.
// RQ20 - Checksum byte is the modulo-256 sum of all preceding data bytes.
module fault_event_recorder
  import fault_event_recorder_pkg::*;
#(
  parameter int unsigned TICK_BASE_CYCLES = TICK_BASE_CYC,
  parameter logic [6:0]  EEPROM_DEV_ADDR  = 7'h50
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic [6:0]  i_event,
  input  wire logic        i_global_fault,
  input  wire logic        i_alert,
  input  wire logic        i_alert_mask,
  input  wire logic [7:0]  i_event_log_config,
  input  wire logic        i_ext_memory_enable,
  input  wire logic        i_eeprom_pins_cfg,
  input  wire logic [15:0] i_status_word,
  input  wire logic [7:0]  i_status_mfr,
  input  wire logic [7:0]  i_status_input,
  input  wire logic [9:0]  i_peak_input_voltage,
  input  wire logic [9:0]  i_peak_input_current,
  input  wire logic [9:0]  i_peak_temperature,
  input  wire logic        i_read_event_log_cmd,
  input  wire logic [3:0]  i_log_rd_addr,
  output logic [7:0]       o_log_rd_data,
  output logic             o_log_rd_valid,
  output logic             o_log_frozen,
  input  wire logic        i_eeprom_serial_clock,
  output logic             o_eeprom_serial_clock,
  output logic             o_eeprom_serial_clock_oe,
  input  wire logic        i_eeprom_serial_data,
  output logic             o_eeprom_serial_data,
  output logic             o_eeprom_serial_data_oe,
  input  wire logic        i_uvlo_above_rise,
  input  wire logic        i_uvlo_above_fall,
  input  wire logic        i_uvlo_above_shutdown,
  output logic             o_fet_on,
  output logic             o_discharge_en,
  output logic             o_shutdown
);
  typedef struct packed {
    logic [6:0]                evt_prev;
    logic                      trig_prev;
    logic [LOG_DEPTH-1:0][7:0] log_entry;
    logic [23:0]               presc;
    logic [3:0]                tick;
    logic                      ovf;
    logic                      frozen;
    logic                      done;
    logic                      nack;
    logic                      seq_busy;
    logic [4:0]                seq_idx;
    logic [7:0]                csum;
    logic [15:0]               snap_sw;
    logic [7:0]                snap_mfr;
    logic [7:0]                snap_inp;
    logic [7:0]                pk_v;
    logic [7:0]                pk_i;
    logic [7:0]                pk_t;
    logic [7:0]                rd_data;
    logic                      rd_valid;
    i2c_state_e                i2c;
    logic [1:0]                phase;
    logic [5:0]                qtr;
    logic [3:0]                bitn;
    logic [8:0]                shreg;
    logic                      scl_oe;
    logic                      sda_oe;
    logic [4:0]                s1;
    logic [4:0]                s2;
    pwr_state_e                pwr;
    logic [15:0]               qod;
    logic                      fet_on;
    logic                      dis;
    logic                      sd;
  } state_s;

  state_s r;
  state_s nxt_r;

  byte_stream_if #(.W(FIFO_W)) seq_bus ();
  byte_stream_if #(.W(FIFO_W)) eng_bus ();

  dump_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .wr        (seq_bus.snk),
    .rd        (eng_bus.src)
  );

  function automatic logic [2:0] event_code(input logic [6:0] hits);
    logic [2:0] code;
    code = 3'h0;
    for (int k = 6; k >= 0; k--) begin
      if (hits[k]) begin
        code = 3'(k + 1);
      end
    end
    return code;
  endfunction

  function automatic logic [7:0] timer_byte(input logic ovf, input logic [3:0] tick);
    logic [7:0] b;
    b = 8'h00;
    b[TMR_OVF_BIT] = ovf;
    b[3:0] = tick;
    return b;
  endfunction

  function automatic logic [7:0] dump_byte(input state_s s, input logic [6:0] dev);
    logic [7:0] b;
    b = 8'h00;
    if (s.seq_idx >= DUMP_LOG_IDX && s.seq_idx < DUMP_TMR_IDX) begin
      b = s.log_entry[3'(s.seq_idx - DUMP_LOG_IDX)];
    end else begin
      unique case (s.seq_idx)
        DUMP_DEV_IDX:   b = {dev, 1'b0};
        DUMP_WADDR_IDX: b = EE_PAGE0_ADDR;
        DUMP_TMR_IDX:   b = timer_byte(s.ovf, s.tick);
        DUMP_SWL_IDX:   b = s.snap_sw[7:0];
        DUMP_SWH_IDX:   b = s.snap_sw[15:8];
        DUMP_MFR_IDX:   b = s.snap_mfr;
        DUMP_INP_IDX:   b = s.snap_inp;
        DUMP_PKV_IDX:   b = s.pk_v;
        DUMP_PKI_IDX:   b = s.pk_i;
        DUMP_PKT_IDX:   b = s.pk_t;
        DUMP_CSUM_IDX:  b = s.csum;
        default:        b = 8'h00;
      endcase
    end
    return b;
  endfunction

  logic [6:0]  evt_rise;
  logic        trig_now;
  logic        dump_ok;
  logic [23:0] tick_term;
  logic        sda_sync;
  logic        scl_sync;
  logic        q_end;

  assign evt_rise  = i_event & ~r.evt_prev;
  assign trig_now  = i_global_fault | (i_alert & ~i_alert_mask); // RQ11
  assign dump_ok   = i_ext_memory_enable && i_eeprom_pins_cfg // RQ14
                     && (|i_event_log_config[CFG_TRIG_LSB +: 3]); // RQ15
  assign tick_term = 24'(TICK_BASE_CYCLES) << {i_event_log_config[CFG_RATE_LSB +: 2], 1'b0}; // RQ8
  assign sda_sync  = r.s2[0];
  assign scl_sync  = r.s2[1];
  // A target holding the clock low stretches the high phase; only looked at once we have
  // released the clock, since during start our own pull-down would stall the quarter forever
  assign q_end     = (r.qtr == 6'(I2C_QTR_CYC - 1))
                     && !(r.phase == 2'h2 && !r.scl_oe && !scl_sync);

  assign seq_bus.valid = r.seq_busy;
  assign seq_bus.data  = {r.seq_idx == DUMP_CSUM_IDX, dump_byte(r, EEPROM_DEV_ADDR)};
  assign eng_bus.ready = (r.i2c == I2C_IDLE)
                         || (r.i2c == I2C_HOLD)
                         || (r.i2c == I2C_BIT && r.phase == 2'h3 && q_end && r.bitn == 4'h8
                             && !r.shreg[8] && !sda_sync);

  always_comb begin
    nxt_r = r;
    nxt_r.s1 = {i_uvlo_above_shutdown, i_uvlo_above_fall, i_uvlo_above_rise,
                i_eeprom_serial_clock, i_eeprom_serial_data};
    nxt_r.s2 = r.s1;
    nxt_r.evt_prev  = i_event;
    nxt_r.trig_prev = trig_now;
    nxt_r.rd_valid  = 1'b0;

    // Tick timer and event capture stop once a dump has frozen the record
    if (!r.frozen) begin
      if (|evt_rise) begin // RQ10
        for (int k = 0; k < LOG_DEPTH - 1; k++) begin
          nxt_r.log_entry[k] = r.log_entry[k + 1]; // RQ2
        end
        nxt_r.log_entry[LOG_DEPTH-1] = {event_code(evt_rise), r.ovf, r.tick}; // RQ4 RQ5 RQ6
        nxt_r.tick  = 4'h0; // RQ7
        nxt_r.ovf   = 1'b0; // RQ9
        nxt_r.presc = 24'h000000;
      end else if (r.presc >= tick_term - 24'h000001) begin
        nxt_r.presc = 24'h000000;
        nxt_r.tick  = r.tick + 4'h1; // RQ7
        if (r.tick == 4'hf) begin
          nxt_r.ovf = 1'b1; // RQ9
        end
      end else begin
        nxt_r.presc = r.presc + 24'h000001;
      end
    end

    if (trig_now && !r.trig_prev && dump_ok && !r.frozen) begin
      nxt_r.frozen   = 1'b1; // RQ13
      nxt_r.seq_busy = 1'b1;
      nxt_r.seq_idx  = DUMP_DEV_IDX;
      nxt_r.csum     = 8'h00;
      nxt_r.snap_sw  = i_status_word;
      nxt_r.snap_mfr = i_status_mfr;
      nxt_r.snap_inp = i_status_input;
      nxt_r.pk_v     = i_peak_input_voltage[9:2]; // RQ17
      nxt_r.pk_i     = i_peak_input_current[9:2]; // RQ17
      nxt_r.pk_t     = i_peak_temperature[9:2]; // RQ17
    end

    // Sequencer stalls on FIFO back-pressure
    if (r.seq_busy && seq_bus.ready) begin
      if (r.seq_idx >= DUMP_LOG_IDX && r.seq_idx < DUMP_CSUM_IDX) begin
        nxt_r.csum = r.csum + seq_bus.data[7:0]; // RQ20
      end
      nxt_r.seq_idx = r.seq_idx + 5'h01; // RQ16
      if (r.seq_idx == DUMP_CSUM_IDX) begin
        nxt_r.seq_busy = 1'b0;
      end
    end

    if (r.i2c != I2C_IDLE && r.i2c != I2C_HOLD) begin
      nxt_r.qtr = q_end ? 6'h00 : (q_end ? r.qtr : ((r.qtr == 6'(I2C_QTR_CYC - 1)) ? r.qtr
                                                  : r.qtr + 6'h01));
      if (q_end) begin
        nxt_r.phase = r.phase + 2'h1;
      end
    end

    unique case (r.i2c)
      I2C_IDLE: begin
        nxt_r.scl_oe = 1'b0;
        nxt_r.sda_oe = 1'b0;
        nxt_r.phase  = 2'h0;
        nxt_r.qtr    = 6'h00;
        // After a refused byte the rest of the dump is discarded
        if (eng_bus.valid && !r.nack) begin
          nxt_r.shreg = eng_bus.data;
          nxt_r.i2c   = I2C_START; // RQ12
        end
      end
      I2C_START: begin
        if (q_end) begin
          unique case (r.phase)
            2'h0: nxt_r.sda_oe = 1'b1;
            2'h1: nxt_r.scl_oe = 1'b1;
            default: begin
              nxt_r.i2c   = I2C_BIT;
              nxt_r.phase = 2'h0;
              nxt_r.bitn  = 4'h0;
            end
          endcase
        end
      end
      I2C_BIT: begin
        if (q_end) begin
          unique case (r.phase)
            2'h0: nxt_r.sda_oe = (r.bitn == 4'h8) ? 1'b0 : !r.shreg[3'(4'h7 - r.bitn)]; // RQ12
            2'h1: nxt_r.scl_oe = 1'b0;
            2'h2: nxt_r.scl_oe = 1'b0;
            default: begin
              nxt_r.scl_oe = 1'b1;
              if (r.bitn != 4'h8) begin
                nxt_r.bitn = r.bitn + 4'h1;
              end else if (sda_sync || r.shreg[8]) begin
                nxt_r.nack = sda_sync;
                nxt_r.i2c  = I2C_STOP;
              end else if (eng_bus.valid) begin
                nxt_r.shreg = eng_bus.data;
                nxt_r.bitn  = 4'h0;
              end else begin
                nxt_r.i2c = I2C_HOLD;
              end
            end
          endcase
        end
      end
      I2C_HOLD: begin
        if (eng_bus.valid) begin
          nxt_r.shreg = eng_bus.data;
          nxt_r.bitn  = 4'h0;
          nxt_r.phase = 2'h0;
          nxt_r.qtr   = 6'h00;
          nxt_r.i2c   = I2C_BIT;
        end
      end
      I2C_STOP: begin
        if (q_end) begin
          unique case (r.phase)
            2'h0: nxt_r.sda_oe = 1'b1;
            2'h1: nxt_r.scl_oe = 1'b0;
            2'h2: begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.done   = 1'b1;
              nxt_r.i2c    = I2C_IDLE;
            end
            default: nxt_r.i2c = I2C_IDLE;
          endcase
        end
      end
      default: nxt_r.i2c = I2C_IDLE;
    endcase

    // Reads never look at the power path, so a unit powered on its logic supply alone answers
    if (i_read_event_log_cmd) begin // RQ1
      nxt_r.rd_valid = 1'b1;
      if (i_log_rd_addr < 4'(LOG_DEPTH)) begin
        nxt_r.rd_data = r.log_entry[3'(i_log_rd_addr)]; // RQ3
      end else if (i_log_rd_addr == RD_ADDR_TIMER) begin
        nxt_r.rd_data = timer_byte(r.ovf, r.tick); // RQ9
      end else if (i_log_rd_addr == RD_ADDR_STATUS) begin
        nxt_r.rd_data = {4'h0, r.seq_busy, r.nack, r.done, r.frozen}; // RQ19
      end else begin
        nxt_r.rd_data = 8'h00;
      end
    end

    if (!r.s2[4]) begin // RQ18
      nxt_r.pwr = PWR_SHUTDOWN;
    end else if (r.s2[2]) begin
      nxt_r.pwr = PWR_ON;
    end else if (!r.s2[3] || r.pwr == PWR_SHUTDOWN) begin
      nxt_r.pwr = PWR_FET_OFF;
    end
    if (nxt_r.pwr != PWR_FET_OFF || r.pwr != PWR_FET_OFF) begin
      nxt_r.qod = 16'h0000;
    end else if (r.qod != 16'(QOD_CYC)) begin
      nxt_r.qod = r.qod + 16'h0001;
    end
    nxt_r.fet_on = (nxt_r.pwr == PWR_ON); // RQ18
    nxt_r.dis    = (nxt_r.pwr == PWR_FET_OFF) && (nxt_r.qod == 16'(QOD_CYC)); // RQ18
    nxt_r.sd     = (nxt_r.pwr == PWR_SHUTDOWN);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      r           <= '0;
      r.log_entry <= {LOG_DEPTH{LOG_ENTRY_RST}};
      r.i2c       <= I2C_IDLE;
      r.pwr       <= PWR_SHUTDOWN;
      r.sd        <= 1'b1;
    end else begin
      r <= nxt_r;
    end
  end

  assign o_log_rd_data            = r.rd_data;
  assign o_log_rd_valid           = r.rd_valid;
  assign o_log_frozen             = r.frozen;
  assign o_eeprom_serial_clock    = 1'b0;
  assign o_eeprom_serial_clock_oe = r.scl_oe;
  assign o_eeprom_serial_data     = 1'b0;
  assign o_eeprom_serial_data_oe  = r.sda_oe;
  assign o_fet_on                 = r.fet_on;
  assign o_discharge_en           = r.dis;
  assign o_shutdown               = r.sd;
endmodule

// ===== src/fault_event_recorder_pkg.sv
// Shared constants and types for the fault event recorder
package fault_event_recorder_pkg;
  localparam int SYS_CLK_KHZ   = 20000;
  localparam int I2C_SCL_KHZ   = 400;
  // Quarter bit period rounded up so the serial clock never runs above its limit
  localparam int I2C_QTR_CYC   = (SYS_CLK_KHZ + 4 * I2C_SCL_KHZ - 1) / (4 * I2C_SCL_KHZ);
  localparam int TICK_BASE_US  = 1000;
  localparam int TICK_BASE_CYC = TICK_BASE_US * (SYS_CLK_KHZ / 1000);
  localparam int QOD_TIME_US   = 10;
  localparam int QOD_CYC       = (QOD_TIME_US * SYS_CLK_KHZ + 999) / 1000;

  localparam int LOG_DEPTH     = 7;
  localparam int FIFO_DEPTH    = 4;
  localparam int FIFO_W        = 9;

  // Byte positions within one dump transaction
  localparam logic [4:0] DUMP_DEV_IDX   = 5'h00;
  localparam logic [4:0] DUMP_WADDR_IDX = 5'h01;
  localparam logic [4:0] DUMP_LOG_IDX   = 5'h02;
  localparam logic [4:0] DUMP_TMR_IDX   = 5'h09;
  localparam logic [4:0] DUMP_SWL_IDX   = 5'h0a;
  localparam logic [4:0] DUMP_SWH_IDX   = 5'h0b;
  localparam logic [4:0] DUMP_MFR_IDX   = 5'h0c;
  localparam logic [4:0] DUMP_INP_IDX   = 5'h0d;
  localparam logic [4:0] DUMP_PKV_IDX   = 5'h0e;
  localparam logic [4:0] DUMP_PKI_IDX   = 5'h0f;
  localparam logic [4:0] DUMP_PKT_IDX   = 5'h10;
  localparam logic [4:0] DUMP_CSUM_IDX  = 5'h11;
  localparam logic [7:0] EE_PAGE0_ADDR  = 8'h00;

  localparam logic [3:0] RD_ADDR_TIMER  = 4'h7;
  localparam logic [3:0] RD_ADDR_STATUS = 4'h8;
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_TRIG_LSB = 2;
  localparam int TMR_OVF_BIT  = 7;
  localparam logic [7:0] LOG_ENTRY_RST = 8'h00;

  typedef enum logic [1:0] {
    PWR_SHUTDOWN = 2'b00,
    PWR_FET_OFF  = 2'b01,
    PWR_ON       = 2'b10
  } pwr_state_e;

  typedef enum logic [2:0] {
    I2C_IDLE  = 3'b000,
    I2C_START = 3'b001,
    I2C_BIT   = 3'b010,
    I2C_HOLD  = 3'b011,
    I2C_STOP  = 3'b100
  } i2c_state_e;
endpackage

// ===== src/byte_stream_if.sv
// Valid/ready byte stream between the dump sequencer, the FIFO and the serial engine
interface byte_stream_if #(parameter int W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== src/dump_fifo.sv
// Small synchronous FIFO holding dump bytes ahead of the serial engine
module dump_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 4
) (
  input  wire logic    i_clk_sys,
  input  wire logic    i_rstn,
  byte_stream_if.snk   wr,
  byte_stream_if.src   rd
);
  localparam int PW = $clog2(DEPTH) + 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wptr;
    logic [PW-1:0]           rptr;
  } fifo_s;

  fifo_s r;
  fifo_s nxt_r;
  logic  full;
  logic  empty;

  assign empty    = (r.wptr == r.rptr);
  assign full     = (r.wptr[PW-2:0] == r.rptr[PW-2:0]) && (r.wptr[PW-1] != r.rptr[PW-1]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = r.mem[r.rptr[PW-2:0]];

  always_comb begin
    nxt_r = r;
    if (wr.valid && !full) begin
      nxt_r.mem[r.wptr[PW-2:0]] = wr.data;
      nxt_r.wptr = r.wptr + PW'(1);
    end
    if (rd.ready && !empty) begin
      nxt_r.rptr = r.rptr + PW'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= nxt_r;
    end
  end
endmodule

// ===== dv/fault_event_recorder_asserts.sv
// Port-level checks for the fault event recorder, bound into the design
module fault_event_recorder_asserts (
  input wire logic       i_clk_sys,
  input wire logic       i_rstn,
  input wire logic       i_read_event_log_cmd,
  input wire logic [3:0] i_log_rd_addr,
  input wire logic [7:0] o_log_rd_data,
  input wire logic       o_log_rd_valid,
  input wire logic       o_log_frozen,
  input wire logic [7:0] i_event_log_config,
  input wire logic       i_ext_memory_enable,
  input wire logic       i_eeprom_pins_cfg,
  input wire logic       o_eeprom_serial_clock_oe,
  input wire logic       o_eeprom_serial_data_oe,
  input wire logic       i_uvlo_above_rise,
  input wire logic       i_uvlo_above_shutdown,
  input wire logic       o_fet_on,
  input wire logic       o_discharge_en,
  input wire logic       o_shutdown
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  logic [7:0] lo_cnt_ff;
  // Saturates so a long held-low clock cannot wrap into a false short pulse
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn || !o_eeprom_serial_clock_oe) lo_cnt_ff <= 8'h00;
    else if (lo_cnt_ff != 8'hff) lo_cnt_ff <= lo_cnt_ff + 8'h01;
  end
  rd_answer_a: assert property (i_read_event_log_cmd |=> o_log_rd_valid)
    else $error("read answer missing");
  rd_pulse_a: assert property (o_log_rd_valid |-> $past(i_read_event_log_cmd))
    else $error("read answer without request");
  rd_unmapped_a: assert property (
    i_read_event_log_cmd && i_log_rd_addr > 4'h8 |=> o_log_rd_data == 8'h00)
    else $error("unmapped read not zero");
  freeze_hold_a: assert property (o_log_frozen |=> o_log_frozen)
    else $error("freeze released");
  freeze_pins_a: assert property (
    $rose(o_log_frozen) |-> $past(i_ext_memory_enable && i_eeprom_pins_cfg))
    else $error("dump without memory enable");
  freeze_trig_a: assert property ($rose(o_log_frozen) |-> $past(|i_event_log_config[4:2]))
    else $error("dump without trigger bit");
  link_idle_a: assert property (
    !o_log_frozen |-> !o_eeprom_serial_clock_oe && !o_eeprom_serial_data_oe)
    else $error("link active without dump");
  dump_start_a: assert property ($rose(o_log_frozen) |-> ##[1:60] o_eeprom_serial_data_oe)
    else $error("dump did not start");
  scl_low_a: assert property ($fell(o_eeprom_serial_clock_oe) |-> lo_cnt_ff >= 8'h0d)
    else $error("serial clock low too short");
  pwr_off_a: assert property (
    !i_uvlo_above_shutdown [*5] |-> o_shutdown && !o_fet_on && !o_discharge_en)
    else $error("not shut down");
  pwr_on_a: assert property (
    i_uvlo_above_rise [*5] |-> o_fet_on && !o_shutdown && !o_discharge_en)
    else $error("not fully on");
endmodule
bind fault_event_recorder fault_event_recorder_asserts fault_event_recorder_asserts_i (
  .i_clk_sys, .i_rstn, .i_read_event_log_cmd, .i_log_rd_addr, .o_log_rd_data,
  .o_log_rd_valid, .o_log_frozen, .i_event_log_config, .i_ext_memory_enable,
  .i_eeprom_pins_cfg, .o_eeprom_serial_clock_oe, .o_eeprom_serial_data_oe,
  .i_uvlo_above_rise, .i_uvlo_above_shutdown, .o_fet_on, .o_discharge_en, .o_shutdown);

// ===== dv/eeprom_model.sv
// Behavioural serial EEPROM on the open-drain link: acks, stretches, keeps bytes
module eeprom_model (
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_stretch,
  output logic      o_scl_low,
  output logic      o_sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:17];
  logic [7:0] sh;
  int         nbit;
  int         nbyte;
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    nbit = 0;
    nbyte = 0;
  end
  always @(negedge i_sda) begin
    if (i_scl) begin
      nbit = 0;
      nbyte = 0;
    end
  end
  always @(posedge i_scl) begin
    sh = {sh[6:0], i_sda};
    nbit = nbit + 1;
  end
  // Holding the clock 4000 ns, about one and a half link periods, models a slow page write
  always @(negedge i_scl) begin
    if (nbit == 8) begin
      if (nbyte < 18) mem[nbyte] = sh;
      nbyte = nbyte + 1;
      o_sda_low = 1'b1;
    end else if (nbit == 9) begin
      nbit = 0;
      o_sda_low = 1'b0;
      if (i_stretch) begin
        o_scl_low = 1'b1;
        #4000;
        o_scl_low = 1'b0;
      end
    end
  end
endmodule

// ===== dv/test_fault_event_recorder.sv
// Self-checking bench for the fault event recorder with an EEPROM model
module test_fault_event_recorder
  import fault_event_recorder_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         TB  = 4;
  localparam logic [6:0] DEV = 7'h2a;  // Arbitrary device address
  logic        i_clk_sys = 1'b0;
  logic        i_rstn, i_global_fault, i_alert, i_alert_mask, i_read_event_log_cmd;
  logic        i_ext_memory_enable, i_eeprom_pins_cfg, o_log_rd_valid, o_log_frozen;
  logic        o_eeprom_serial_clock, o_eeprom_serial_clock_oe, o_eeprom_serial_data;
  logic        o_eeprom_serial_data_oe, i_uvlo_above_rise, i_uvlo_above_fall;
  logic        i_uvlo_above_shutdown, o_fet_on, o_discharge_en, o_shutdown, scl_low, sda_low, f;
  logic [6:0]  i_event;
  logic [3:0]  i_log_rd_addr;
  logic [15:0] i_status_word;
  logic [7:0]  i_event_log_config, i_status_mfr, i_status_input, o_log_rd_data, cfg, tmr, sum, e;
  logic [9:0]  i_peak_input_voltage, i_peak_input_current, i_peak_temperature;
  logic [55:0] tail;
  logic [7:0]  exp_log [$];
  wire logic   i_eeprom_serial_clock, i_eeprom_serial_data;
  int          seed = 32'h53496766;
  int          n_fail = 0, comparisons = 0, per, k, b;
  assign i_eeprom_serial_clock = !(o_eeprom_serial_clock_oe || scl_low);
  assign i_eeprom_serial_data  = !(o_eeprom_serial_data_oe || sda_low);
  always #25 i_clk_sys = ~i_clk_sys;
  fault_event_recorder #(.TICK_BASE_CYCLES(TB), .EEPROM_DEV_ADDR(DEV)) fault_event_recorder_i (
    .i_clk_sys, .i_rstn, .i_event, .i_global_fault, .i_alert, .i_alert_mask,
    .i_event_log_config, .i_ext_memory_enable, .i_eeprom_pins_cfg, .i_status_word,
    .i_status_mfr, .i_status_input, .i_peak_input_voltage, .i_peak_input_current,
    .i_peak_temperature, .i_read_event_log_cmd, .i_log_rd_addr, .o_log_rd_data,
    .o_log_rd_valid, .o_log_frozen, .i_eeprom_serial_clock, .o_eeprom_serial_clock,
    .o_eeprom_serial_clock_oe, .i_eeprom_serial_data, .o_eeprom_serial_data,
    .o_eeprom_serial_data_oe, .i_uvlo_above_rise, .i_uvlo_above_fall,
    .i_uvlo_above_shutdown, .o_fet_on, .o_discharge_en, .o_shutdown);
  eeprom_model eeprom_model_i (.i_scl(i_eeprom_serial_clock), .i_sda(i_eeprom_serial_data),
    .i_stretch(1'b1), .o_scl_low(scl_low), .o_sda_low(sda_low));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    @(posedge i_clk_sys);
    i_read_event_log_cmd <= 1'b1;
    i_log_rd_addr <= a;
    @(posedge i_clk_sys);
    i_read_event_log_cmd <= 1'b0;
    #1;
    chk(8'(o_log_rd_valid), 8'h01);
    chk(o_log_rd_data, x);
  endtask
  task automatic pwr(input logic [2:0] c, input int n, input logic [2:0] x);
    @(posedge i_clk_sys);
    {i_uvlo_above_rise, i_uvlo_above_fall, i_uvlo_above_shutdown} <= c;
    cyc(n);
    chk(8'({o_fet_on, o_discharge_en, o_shutdown}), 8'(x));
  endtask
  task automatic trg(input logic [7:0] c, input logic en, input logic p, input logic ft,
                     input logic al, input logic x);
    @(posedge i_clk_sys);
    i_event_log_config <= c;
    i_ext_memory_enable <= en;
    i_eeprom_pins_cfg <= p;
    i_global_fault <= ft;
    i_alert <= al;
    cyc(4);
    chk(8'(o_log_frozen), 8'(x));
    @(posedge i_clk_sys);
    {i_global_fault, i_alert} <= 2'b00;
  endtask
  // Rate changes land on the event edge, where the prescaler restarts anyway
  task automatic ev(input logic [6:0] m, input int g, input logic [1:0] r);
    repeat (g - 1) @(posedge i_clk_sys);
    cfg[1:0] = r;
    i_event <= m;
    i_event_log_config <= cfg;
    @(posedge i_clk_sys);
    i_event <= 7'h00;
  endtask
  initial begin
    {i_rstn, i_global_fault, i_alert, i_read_event_log_cmd} = 4'h0;
    {i_event, i_log_rd_addr, i_event_log_config} = 19'h0;
    {i_alert_mask, i_ext_memory_enable, i_eeprom_pins_cfg} = 3'b111;
    {i_uvlo_above_rise, i_uvlo_above_fall, i_uvlo_above_shutdown} = 3'b000;
    cfg = {3'b000, 3'($unsigned($random(seed)) % 7 + 1), 2'b00};
    i_status_word = 16'($random(seed));
    {i_status_mfr, i_status_input} = 16'($random(seed));
    {i_peak_input_voltage, i_peak_input_current, i_peak_temperature} = 30'($random(seed));
    repeat (8) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h9 + 4'($unsigned($random(seed)) % 7), 8'h00);
    pwr(3'b111, 6, 3'b100);
    pwr(3'b001, 10, 3'b000);
    pwr(3'b001, 250, 3'b010);
    pwr(3'b000, 6, 3'b001);
    pwr(3'b111, 6, 3'b100);
    trg(8'h00, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    trg(cfg, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    trg(cfg, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    trg(cfg, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    per = TB;
    for (int j = 0; j < 10; j++) begin
      b = (j + 4) % 7;
      k = (j == 3) ? 16 : (j == 4) ? 0 : $unsigned($random(seed)) % 20;
      ev(7'(1 << b) | ((j == 8) ? 7'h40 : 7'h00), per * k + per / 2, 2'(j % 4));
      exp_log.push_back({3'(b + 1), k >= 16, 4'(k)});
      per = TB << (2 * (j % 4));
    end
    k = $unsigned($random(seed)) % 20;
    repeat (per * k + per / 2 - 2) @(posedge i_clk_sys);
    i_alert_mask <= 1'b0;
    f = 1'($random(seed));
    trg(cfg, 1'b1, 1'b1, f, !f, 1'b1);
    tmr = {k >= 16, 3'b000, 4'(k)};
    for (int i = 0; i < 1000 && eeprom_model_i.nbyte < 18; i++) cyc(50);
    if (eeprom_model_i.nbyte < 18) n_fail++;
    cyc(300);
    chk(8'({o_eeprom_serial_clock, o_eeprom_serial_data}), 8'h00);
    rd(RD_ADDR_STATUS, 8'h03);
    ev(7'h01, 4, cfg[1:0]);
    cyc(4);
    sum = 8'h00;
    chk(eeprom_model_i.mem[DUMP_DEV_IDX], {DEV, 1'b0});
    chk(eeprom_model_i.mem[DUMP_WADDR_IDX], EE_PAGE0_ADDR);
    for (int i = 0; i < 7; i++) begin
      e = exp_log[exp_log.size() - 7 + i];
      rd(4'(i), e);
      chk(eeprom_model_i.mem[2 + i], e);
      sum += e;
    end
    rd(RD_ADDR_TIMER, tmr);
    chk(eeprom_model_i.mem[DUMP_TMR_IDX], tmr);
    sum += tmr;
    tail = {i_status_word[7:0], i_status_word[15:8], i_status_mfr, i_status_input,
            i_peak_input_voltage[9:2], i_peak_input_current[9:2], i_peak_temperature[9:2]};
    for (int i = 0; i < 7; i++) begin
      chk(eeprom_model_i.mem[10 + i], tail[55 - 8 * i -: 8]);
      sum += tail[55 - 8 * i -: 8];
    end
    chk(eeprom_model_i.mem[DUMP_PKT_IDX], i_peak_temperature[9:2]);
    chk(eeprom_model_i.mem[DUMP_CSUM_IDX], sum);
    final_report();
  end
endmodule
